//--- rst_pll_pkg.sv
// Constants and types for the reset and clock-lock sequencer.
// Assumes one clock, i_clk_sys, standing in for the oscillator clock.
package rst_pll_pkg;

  // ==========================================================
  // Timing counts in oscillator cycles, and the width of the shared counter.
  // ==========================================================
  localparam int unsigned WD_PULSE_CYC   = 512;
  localparam int unsigned POST_RST_CYC   = 32;
  localparam int unsigned STRAP_HOLD_CYC = 200;
  localparam int unsigned LOCK_CYC       = 131072;
  localparam int unsigned CNT_W          = 18;

  // ==========================================================
  // Multiplier encodings and reset values.
  // ==========================================================
  localparam logic [15:0] MULT_X2    = 16'h0004;
  localparam logic [15:0] MULT_X4    = 16'h0008;
  localparam logic [15:0] MULT_RST   = 16'h0000;
  localparam logic [1:0]  OUTDIV_RST = 2'h0;

  // System clock rate selection presented to the clock generator.
  typedef enum logic [2:0]
  {
    RATE_HALF  = 3'h0,
    RATE_X1    = 3'h1,
    RATE_X2    = 3'h2,
    RATE_X4    = 3'h3,
    RATE_LIMP  = 3'h4
  } rate_t;

  // Sequencer states, Gray coded along the usual path.
  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,
    ST_WAIT  = 2'b01,
    ST_RUN   = 2'b11,
    ST_LOCK  = 2'b10
  } seq_state_t;

endpackage : rst_pll_pkg

//--- reset_and_pll_lock_sequencer.sv
// Reset stretching, post-reset delay, boot strap capture and PLL lock sequencing.
// Assumes i_clk_sys is the oscillator clock and the reset pin arrives asynchronously.
// The clock generator and the clock output divider themselves sit outside this block.
`timescale 1ns/1ps
`default_nettype none

module reset_and_pll_lock_sequencer
  import rst_pll_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  // External pins.
  input  wire logic        i_reset_n_pin,
  input  wire logic [3:0]  i_boot_mode,
  // Internal sources.
  input  wire logic        i_wd_trip,
  input  wire logic        i_mult_wr,
  input  wire logic [15:0] i_mult_data,
  input  wire logic        i_limp,
  input  wire logic        i_outdiv_wr,
  input  wire logic [1:0]  i_outdiv_data,
  // Status and clock control.
  output logic             o_core_rst,
  output logic             o_bus_ready,
  output logic [3:0]       o_boot_sel,
  output logic             o_boot_valid,
  output logic [2:0]       o_sysclk_rate,
  output logic [1:0]       o_clkout_div,
  output logic [15:0]      o_pll_mult,
  output logic             o_locking
);

  // ==========================================================
  // State record.
  // ==========================================================
  // Every flop of the block lives in this one record, synchronisers included.
  // The strap pins are as asynchronous as the reset pin.
  // They get their own two stages, and the capture reads only the second one.
  // The counter cnt serves both the post-release wait and the lock phase.
  // The two never overlap, so one counter is enough.
  typedef struct packed
  {
    logic [1:0]       pin_sync;
    logic [3:0]       boot_meta;
    logic [3:0]       boot_sync;
    seq_state_t       st;
    logic [CNT_W-1:0] cnt;
    logic [9:0]       wd_cnt;
    logic [3:0]       boot;
    logic             boot_ok;
    logic [15:0]      mult;
    logic [1:0]       outdiv;
    logic [2:0]       rate;
  } state_t;

  state_t cur;
  state_t next_cur;

  // Reset pin level after two flops; only the second stage is read.
  // The first stage may go metastable when the pin moves near a clock edge.
  // It is therefore read by nothing except the second stage.
  logic pin_high;
  assign pin_high = cur.pin_sync[1];

  // ==========================================================
  // Next-state logic.
  // ==========================================================
  always_comb
  begin
    next_cur = cur;
    next_cur.pin_sync = {cur.pin_sync[0], i_reset_n_pin};
    next_cur.boot_meta = i_boot_mode;
    next_cur.boot_sync = cur.boot_meta;
    // A divider write while the core is held in reset is dropped.
    // The output pin then keeps its reset divide-by-four until the sequence leaves RESET.
    if (i_outdiv_wr && cur.st != ST_RESET)
    begin
      next_cur.outdiv = i_outdiv_data;
    end
    // watchdog pulse stretch
    // The counter is loaded on the trip and runs down to zero.
    // The sequence leaves RESET on its last count, so the pulse is exactly its length.
    if (i_wd_trip)
    begin
      next_cur.wd_cnt = 10'(WD_PULSE_CYC);
    end
    else if (cur.wd_cnt != 10'h000)
    begin
      next_cur.wd_cnt = cur.wd_cnt - 10'h001;
    end
    // Main sequence: RESET, WAIT, RUN and LOCK along the Gray coded path.
    case (cur.st)
      ST_RESET:
      begin
        next_cur.cnt = '0;
        next_cur.rate = RATE_HALF;
        // A watchdog count of one is the last reset cycle.
        // Leaving on it keeps the pulse from growing by one cycle.
        if (pin_high && cur.wd_cnt <= 10'h001 && !i_wd_trip)
        begin
          next_cur.st = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        next_cur.cnt = cur.cnt + 1'b1;
        if (cur.cnt == CNT_W'(POST_RST_CYC - 1))
        begin
          next_cur.st  = ST_RUN;
          next_cur.cnt = '0;
          // capture boot straps
          // Straps are taken long before the far side may move them again.
          next_cur.boot    = cur.boot_sync;
          next_cur.boot_ok = 1'b1;
        end
      end
      ST_RUN:
      begin
        // limp mode rate
        // Limp rate holds until a lock starts or a reset; it is not undone here.
        if (i_limp)
        begin
          next_cur.rate = RATE_LIMP;
        end
        if (i_mult_wr && i_mult_data != cur.mult)
        begin
          next_cur.mult = i_mult_data;
          next_cur.st   = ST_LOCK;
          next_cur.cnt  = '0;
          next_cur.rate = RATE_HALF;
        end
      end
      ST_LOCK:
      begin
        next_cur.cnt = cur.cnt + 1'b1;
        // The count runs from the write, so the half-rate phase spans the full lock count.
        // rewrite restarts count
        // A rewrite is taken without a value compare, since the loop relocks anyway.
        if (i_mult_wr)
        begin
          next_cur.mult = i_mult_data;
          next_cur.cnt  = '0;
        end
        else if (cur.cnt == CNT_W'(LOCK_CYC - 1))
        begin
          next_cur.st  = ST_RUN;
          next_cur.cnt = '0;
          // multiplier to rate
          // Unlisted multiplier values fall back to the x1 rate.
          case (cur.mult)
            MULT_X2: next_cur.rate = RATE_X2;
            MULT_X4: next_cur.rate = RATE_X4;
            MULT_RST: next_cur.rate = RATE_X1;
            default: next_cur.rate = RATE_X1;
          endcase
          if (i_limp)
          begin
            next_cur.rate = RATE_LIMP;
          end
        end
      end
      default:
      begin
        next_cur.st = ST_RESET;
      end
    endcase
    // Pin low or watchdog pulse forces a full restart of the sequence.
    // The last watchdog count is left to the RESET branch, which may then move on.
    // Clearing the multiplier here means that the first nonzero write in RUN after reset locks.
    if (!pin_high || i_wd_trip || cur.wd_cnt > 10'h001)
    begin
      next_cur.st      = ST_RESET;
      next_cur.boot_ok = 1'b0;
      next_cur.mult    = MULT_RST;
      next_cur.outdiv  = OUTDIV_RST;
    end
  end

  // ==========================================================
  // State register.
  // ==========================================================
  // Everything, synchronisers included, is cleared by the system reset.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cur <= '{pin_sync: 2'h0, boot_meta: 4'h0, boot_sync: 4'h0, st: ST_RESET, cnt: '0,
               wd_cnt: 10'h000, boot: 4'h0, boot_ok: 1'b0, mult: MULT_RST,
               outdiv: OUTDIV_RST, rate: RATE_HALF};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // ==========================================================
  // Outputs.
  // ==========================================================
  // Status flags decode flop outputs only, so they change once per edge.
  // The state codes are Gray along the path, which keeps the decodes free of races.
  assign o_core_rst    = (cur.st == ST_RESET) || (cur.wd_cnt != 10'h000);
  assign o_bus_ready   = (cur.st == ST_RUN) || (cur.st == ST_LOCK);
  assign o_boot_sel    = cur.boot;
  assign o_boot_valid  = cur.boot_ok;
  assign o_sysclk_rate = cur.rate;
  // divider zero means divide by four
  assign o_clkout_div  = cur.outdiv;
  assign o_pll_mult    = cur.mult;
  assign o_locking     = (cur.st == ST_LOCK);

endmodule : reset_and_pll_lock_sequencer

`default_nettype wire

//--- seq_properties.sv
// Checker for the reset and lock sequencer ports.
// Assumes one clock domain and the package compiled first.
`timescale 1ns/1ps
`default_nettype none
module seq_properties
  import rst_pll_pkg::*;
(
  // Clock and reset.
  input wire logic        i_clk_sys, i_sys_rst,
  // Watched ports.
  input wire logic        i_wd_trip, i_mult_wr, i_limp, i_reset_n_pin,
  input wire logic        o_core_rst, o_bus_ready, o_boot_valid, o_locking,
  input wire logic [15:0] i_mult_data, o_pll_mult,
  input wire logic [3:0]  i_boot_mode, o_boot_sel,
  input wire logic [2:0]  o_sysclk_rate,
  input wire logic [1:0]  o_clkout_div
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Locked cycles since the last write; only a write or the system reset clears it.
  logic [CNT_W-1:0] lk;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst) lk <= '0;
    else lk <= i_mult_wr ? '0 : lk + CNT_W'(o_locking);
  // Core reset cycles since the last watchdog trip, saturating.
  logic [9:0] wdc;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst) wdc <= 10'h3ff;
    else wdc <= i_wd_trip ? 10'h000 : wdc + 10'(o_core_rst && wdc != 10'h3ff);
  sequence lock_go;
    i_mult_wr && o_bus_ready && !o_locking && i_mult_data != o_pll_mult;
  endsequence
  sequence ready_rise;
    !o_bus_ready [*8] ##28 $rose(o_bus_ready);
  endsequence
  wd_pulse_a: assert property (i_wd_trip |=> o_core_rst [*8])
    else $error("watchdog reset short");
  wd_len_a: assert property ($fell(o_core_rst) && wdc <= 10'(WD_PULSE_CYC)
    |-> wdc == 10'(WD_PULSE_CYC)) else $error("watchdog reset length");
  ready_delay_a: assert property ($rose(i_reset_n_pin) |-> ready_rise)
    else $error("bus ready timing");
  boot_cap_a: assert property ($rose(o_boot_valid) |-> o_boot_sel == $past(i_boot_mode, 3))
    else $error("boot straps");
  lock_start_a: assert property (lock_go |=> o_locking && o_sysclk_rate == RATE_HALF
    && o_pll_mult == $past(i_mult_data)) else $error("lock start");
  lock_half_a: assert property (o_locking |-> o_sysclk_rate == RATE_HALF)
    else $error("lock rate");
  lock_len_a: assert property ($fell(o_locking) && !o_core_rst |-> lk == CNT_W'(LOCK_CYC))
    else $error("lock length");
  new_rate_a: assert property ($fell(o_locking) && !o_core_rst |-> $past(i_limp) ||
    o_sysclk_rate ==
    (o_pll_mult == MULT_X4 ? RATE_X4 : o_pll_mult == MULT_X2 ? RATE_X2 : RATE_X1))
    else $error("rate after lock");
  limp_rate_a: assert property (o_bus_ready && !o_locking && i_limp && !i_mult_wr
    |=> o_sysclk_rate == RATE_LIMP) else $error("limp rate");
  div_reset_a: assert property ($fell(o_core_rst) |-> o_clkout_div == OUTDIV_RST)
    else $error("divider reset");
endmodule : seq_properties
bind reset_and_pll_lock_sequencer seq_properties u_seq_properties (.*);
`default_nettype wire

//--- reset_partner.sv
// Model of the reset supervisor and boot strap pins.
// Assumes requests arrive at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module reset_partner (
  input  wire logic       i_clk_sys,
  input  wire logic       i_req,
  input  wire logic [3:0] i_mode,
  output logic            o_pin_n,
  output logic [3:0]      o_boot
);
  int   n    = 1;
  logic hold = 1'b1;
  initial o_pin_n = 1'b0;
  initial o_boot = 4'h0;
  // Requests are taken on the rising edge so the falling-edge driver never races the bench.
  always @(posedge i_clk_sys)
  begin
    hold <= i_req;
  end
  // pin low eight, straps held, then released to a toggling pattern.
  always @(negedge i_clk_sys)
  begin
    n <= hold ? 1 : n + 1;
    o_pin_n <= !(hold || n < 8);
    o_boot <= hold ? i_mode : (n > 208 ? ~o_boot : o_boot);
  end
endmodule : reset_partner
`default_nettype wire

//--- tb_reset_and_pll_lock_sequencer.sv
// Bench for the sequencer with a model of the reset pin driver.
// Assumes the package, design and partner are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_reset_and_pll_lock_sequencer;
  import rst_pll_pkg::*;
  logic clk = 0, rst = 1, req = 0, wd = 0, wr = 0, limp = 0, dwr = 0, pin, crst, rdy, bval, lck;
  logic [3:0] mode, boot, bsel;
  logic [15:0] wdat = 0, mult;
  logic [1:0] ddat = 0, div;
  logic [2:0] rate;
  int n_errors = 0, n_checks = 0, k, m;
  int unsigned boot_q[$];
  reset_and_pll_lock_sequencer u_reset_and_pll_lock_sequencer (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_reset_n_pin(pin), .i_boot_mode(boot), .i_wd_trip(wd), .i_mult_wr(wr), .i_mult_data(wdat),
    .i_limp(limp), .i_outdiv_wr(dwr), .i_outdiv_data(ddat), .o_core_rst(crst), .o_bus_ready(rdy),
    .o_boot_sel(bsel), .o_boot_valid(bval), .o_sysclk_rate(rate), .o_clkout_div(div),
    .o_pll_mult(mult), .o_locking(lck));
  reset_partner u_reset_partner (.i_clk_sys(clk), .i_req(req), .i_mode(mode), .o_pin_n(pin),
    .o_boot(boot));
  initial forever #5 clk = ~clk;
  // Reference rate for a multiplier value.
  function automatic int rate_of(int v);
    return v == 8 ? 3 : v == 4 ? 2 : 1;
  endfunction : rate_of
  task chk(input string s, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", s, exp, got);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // Bounded wait for bus ready; a hang ends the run.
  task till_rdy;
    for (k = 0; k < 99 && rdy !== 1'b1; k++) @(negedge clk);
    if (rdy !== 1'b1)
    begin
      n_errors++;
      end_of_test;
    end
  endtask : till_rdy
  task pulse_wr(input logic [15:0] v);
    wr = 1;
    wdat = v;
    @(negedge clk);
    wr = 0;
  endtask : pulse_wr
  // ==========================================================
  // Main sequence.
  // ==========================================================
  initial
  begin
    k = $urandom(20);
    mode = 4'($urandom);
    boot_q.push_back(mode);
    req = 1;
    repeat (5) @(negedge clk);
    rst = 0;
    req = 0;
    chk("rate", rate, RATE_HALF);
    chk("div", div, OUTDIV_RST);
    for (int i = 0; i < 3; i++)
    begin
      till_rdy;
      chk("boot", bsel, boot_q.pop_front());
      chk("valid", bval, 1'b1);
      ddat = 2'($urandom);
      dwr = 1;
      @(negedge clk);
      dwr = 0;
      @(negedge clk);
      chk("div", div, ddat);
      repeat (200) @(negedge clk);
      mode = 4'($urandom);
      boot_q.push_back(mode);
      req = 1;
      repeat (4) @(negedge clk);
      req = 0;
      chk("pin rst", crst, 1'b1);
      $display("reset test %0d done", i);
    end
    till_rdy;
    wd = 1;
    @(negedge clk);
    wd = 0;
    for (k = 0; k < 3 && crst !== 1'b1; k++) @(negedge clk);
    for (m = 0; m < 600 && crst === 1'b1; m++) @(negedge clk);
    chk("wd len", m, WD_PULSE_CYC);
    chk("div", div, OUTDIV_RST);
    till_rdy;
    pulse_wr(MULT_X4);
    repeat (50) @(negedge clk);
    chk("lock", lck, 1'b1);
    chk("half", rate, RATE_HALF);
    chk("mult", mult, MULT_X4);
    pulse_wr(MULT_X2);
    for (m = 0; m < 140000 && lck === 1'b1; m++) @(negedge clk);
    chk("lock len", m, LOCK_CYC);
    chk("rate", rate, rate_of(MULT_X2));
    pulse_wr(MULT_X2);
    chk("same", lck, 1'b0);
    limp = 1;
    repeat (2) @(negedge clk);
    chk("limp", rate, RATE_LIMP);
    $display("lock test done");
    end_of_test;
  end
endmodule : tb_reset_and_pll_lock_sequencer
`default_nettype wire
